//--- async_serial_tx_rx_test.sv
// self-checking bench: Avalon-MM register tasks plus a remote serial node
// assumes divisor 0 with high speed baud, so a bit spans 16 clocks
`timescale 1ns/1ps
module async_serial_tx_rx_test
  import serial_port_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rst_b;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        rx_pin;
  logic        tx_pin;
  logic        irq_request;
  logic [9:0]  got_a;
  logic [9:0]  got_b;
  int          failures = 0;
  int          checks_done = 0;
  int          cycles = 0;
  always #5 sys_clk = ~sys_clk;
  serial_tx_rx serial_tx_rx_i (.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_pin(rx_pin),
    .tx_pin(tx_pin), .irq_request(irq_request));
  serial_node serial_node_i (.sys_clk(sys_clk), .tx_pin(tx_pin), .rx_pin(rx_pin));
  // ****************
  // tasks
  // ****************
  task automatic close_out();
    if (failures == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    checks_done++;
    if (got !== want) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= {24'h000000, d};
    avs_write     <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] want);
    @(posedge sys_clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    check(avs_readdata, want);
  endtask
  task automatic tx_one(input logic [7:0] d, input int nb, input logic [9:0] want);
    fork
      serial_node_i.capture(nb, got_a);
      wr(OFF_TRANSMIT_BUFFER, d);
    join
    check({22'h000000, got_a}, {22'h000000, want});
  endtask
  task automatic rx_one(input logic [8:0] d, input int nb, input logic stop);
    serial_node_i.send(d, nb, stop);
    repeat (8) @(posedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      close_out();
    end
  end
  // ****************
  // sequence
  // ****************
  initial begin
    rst_b = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(OFF_PERIPHERAL_FLAGS_ONE, 32'h00);
    rd(OFF_RECEIVE_STATUS_CONTROL, 32'h00);
    wr(OFF_RECEIVE_STATUS_CONTROL, 8'h90);
    wr(OFF_BAUD_DIVISOR_LOW, 8'h00);
    wr(OFF_TRANSMIT_STATUS_CONTROL, 8'h24);
    rd(OFF_PERIPHERAL_FLAGS_ONE, 32'h10);
    wr(OFF_PERIPHERAL_FLAGS_ONE, 8'h00);
    rd(OFF_PERIPHERAL_FLAGS_ONE, 32'h10);
    rd(OFF_TRANSMIT_STATUS_CONTROL, 32'h26);
    rd(6'h3c, 32'h00);
    fork
      begin
        serial_node_i.capture(8, got_a);
        serial_node_i.capture(8, got_b);
      end
      begin
        wr(OFF_TRANSMIT_BUFFER, 8'ha5);
        rd(OFF_PERIPHERAL_FLAGS_ONE, 32'h00);
        wr(OFF_TRANSMIT_BUFFER, 8'h3c);
        rd(OFF_PERIPHERAL_FLAGS_ONE, 32'h00);
        rd(OFF_TRANSMIT_STATUS_CONTROL, 32'h24);
      end
    join
    check({22'h000000, got_a}, 32'h1a5);
    check({22'h000000, got_b}, 32'h13c);
    repeat (16) @(posedge sys_clk);
    rd(OFF_PERIPHERAL_FLAGS_ONE, 32'h10);
    rd(OFF_TRANSMIT_STATUS_CONTROL, 32'h26);
    wr(OFF_TRANSMIT_STATUS_CONTROL, 8'h65);
    tx_one(8'h5a, 9, 10'h35a);
    wr(OFF_TRANSMIT_STATUS_CONTROL, 8'h24);
    wr(OFF_BAUD_CONTROL, 8'h10);
    serial_node_i.inv_tx <= 1'b1;
    repeat (16) @(posedge sys_clk);
    check({31'h0, tx_pin}, 32'h0);
    tx_one(8'h81, 8, 10'h181);
    wr(OFF_BAUD_CONTROL, 8'h00);
    serial_node_i.inv_tx <= 1'b0;
    wr(OFF_PERIPHERAL_ENABLES_ONE, 8'h20);
    wr(OFF_INTERRUPT_CONTROL, 8'hc0);
    rx_one(9'h03c, 8, 1'b1);
    check({31'h0, irq_request}, 32'h1);
    rd(OFF_PERIPHERAL_FLAGS_ONE, 32'h30);
    rd(OFF_RECEIVE_BUFFER, 32'h3c);
    rd(OFF_PERIPHERAL_FLAGS_ONE, 32'h10);
    check({31'h0, irq_request}, 32'h0);
    rx_one(9'h055, 8, 1'b0);
    rd(OFF_RECEIVE_STATUS_CONTROL, 32'h94);
    rd(OFF_RECEIVE_BUFFER, 32'h55);
    wr(OFF_RECEIVE_STATUS_CONTROL, 8'h80);
    rd(OFF_RECEIVE_STATUS_CONTROL, 32'h80);
    rx_one(9'h077, 8, 1'b1);
    rd(OFF_PERIPHERAL_FLAGS_ONE, 32'h10);
    wr(OFF_RECEIVE_STATUS_CONTROL, 8'h90);
    rx_one(9'h011, 8, 1'b1);
    rx_one(9'h022, 8, 1'b1);
    rd(OFF_RECEIVE_STATUS_CONTROL, 32'h92);
    rd(OFF_RECEIVE_BUFFER, 32'h11);
    wr(OFF_RECEIVE_STATUS_CONTROL, 8'h80);
    rd(OFF_RECEIVE_STATUS_CONTROL, 32'h80);
    wr(OFF_RECEIVE_STATUS_CONTROL, 8'hd0);
    rx_one(9'h1a5, 9, 1'b1);
    rd(OFF_RECEIVE_STATUS_CONTROL, 32'hd1);
    rd(OFF_RECEIVE_BUFFER, 32'ha5);
    wr(OFF_RECEIVE_STATUS_CONTROL, 8'hd8);
    rx_one(9'h042, 9, 1'b1);
    rd(OFF_PERIPHERAL_FLAGS_ONE, 32'h10);
    rx_one(9'h107, 9, 1'b1);
    rd(OFF_RECEIVE_STATUS_CONTROL, 32'hd9);
    rd(OFF_RECEIVE_BUFFER, 32'h07);
    wr(OFF_RECEIVE_STATUS_CONTROL, 8'hd0);
    rx_one(9'h033, 9, 1'b1);
    rd(OFF_RECEIVE_BUFFER, 32'h33);
    wr(OFF_RECEIVE_STATUS_CONTROL, 8'h80);
    wr(OFF_BAUD_CONTROL, 8'h20);
    serial_node_i.inv_rx <= 1'b1;
    wr(OFF_RECEIVE_STATUS_CONTROL, 8'h90);
    rx_one(9'h0c3, 8, 1'b1);
    rd(OFF_RECEIVE_BUFFER, 32'hc3);
    rd(OFF_BAUD_CONTROL, 32'h60);
    wr(OFF_PERIPHERAL_PRIORITY_ONE, 8'h30);
    rd(OFF_PERIPHERAL_PRIORITY_ONE, 32'h30);
    close_out();
  end
endmodule

//--- serial_baud_gen.sv
// baud rate generator: one-cycle pulse at sixteen times the bit rate
// assumes divisor and mode bits held stable by software while in use
`timescale 1ns/1ps
module serial_baud_gen
  import serial_port_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       enable,
  input  wire logic       high_speed_baud,
  input  wire logic       sixteen_bit_baud,
  input  wire logic [7:0] baud_divisor_high,
  input  wire logic [7:0] baud_divisor_low,
  output logic            sample_tick
);

  typedef struct packed {
    logic [15:0] cnt;
    logic [1:0]  pre;
    logic        tick;
  } baud_state_t;

  baud_state_t s_q;
  baud_state_t s_d;
  logic [15:0] divisor;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    divisor = sixteen_bit_baud ? {baud_divisor_high, baud_divisor_low}
                               : {8'h00, baud_divisor_low};
    if (!enable) begin
      s_d.cnt = divisor;
      s_d.pre = 2'h0;
    end else if (s_d.cnt == 16'h0000) begin
      s_d.cnt = divisor;
      // x64 clock needs a further divide by four for the x16 sampler
      if (!high_speed_baud && !sixteen_bit_baud) begin
        s_d.pre = s_d.pre + 2'h1;
        s_d.tick = (s_q.pre == PRESCALE_X64_LAST);
      end else begin
        s_d.tick = 1'b1;
      end
    end else begin
      s_d.cnt = s_q.cnt - 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sample_tick = s_q.tick;

endmodule

//--- serial_node.sv
// remote asynchronous serial node: sends frames on rx_pin, captures tx_pin
// assumes a bit time of 16 sys_clk cycles; line idles at mark
`timescale 1ns/1ps
module serial_node
  import serial_port_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic tx_pin,
  output logic      rx_pin
);
  localparam int BIT_CLKS = 16;
  logic line_q = 1'b1;
  logic inv_rx = 1'b0;
  logic inv_tx = 1'b0;
  // inverting line buffer in front of the receiver
  assign rx_pin = line_q ^ inv_rx;
  // start, nb data bits lsb first, stop
  task automatic send(input logic [8:0] d, input int nb, input logic stop);
    logic [10:0] f;
    int          i;
    f = 11'h7ff;
    f[0] = 1'b0;
    for (i = 0; i < nb; i++) begin
      f[i+1] = d[i];
    end
    f[nb+1] = stop;
    @(posedge sys_clk);
    for (i = 0; i < nb + 2; i++) begin
      line_q <= f[i];
      repeat (BIT_CLKS) @(posedge sys_clk);
    end
    line_q <= 1'b1;
  endtask
  // got[nb-1:0] data, got[nb] stop, sampled mid-bit
  task automatic capture(input int nb, output logic [9:0] got);
    int i;
    got = 10'h000;
    do @(posedge sys_clk); while ((tx_pin ^ inv_tx) !== 1'b0);
    repeat (BIT_CLKS / 2) @(posedge sys_clk);
    for (i = 0; i <= nb; i++) begin
      repeat (BIT_CLKS) @(posedge sys_clk);
      got[i] = tx_pin ^ inv_tx;
    end
  endtask
endmodule

//--- serial_port_pkg.sv
// register map, field positions and timing constants of the serial port
// assumes a 100 MHz sys_clk and an Avalon-MM slave with byte addresses
package serial_port_pkg;

  // ****************
  // register byte offsets
  // ****************
  localparam logic [5:0] OFF_INTERRUPT_CONTROL         = 6'h00,
                         OFF_PERIPHERAL_FLAGS_ONE      = 6'h04,
                         OFF_PERIPHERAL_ENABLES_ONE    = 6'h08,
                         OFF_PERIPHERAL_PRIORITY_ONE   = 6'h0c,
                         OFF_RECEIVE_STATUS_CONTROL    = 6'h10,
                         OFF_TRANSMIT_BUFFER           = 6'h14,
                         OFF_TRANSMIT_STATUS_CONTROL   = 6'h18,
                         OFF_BAUD_CONTROL              = 6'h1c,
                         OFF_BAUD_DIVISOR_HIGH         = 6'h20,
                         OFF_RECEIVE_BUFFER            = 6'h24,
                         OFF_BAUD_DIVISOR_LOW          = 6'h28;

  // ****************
  // field positions
  // ****************
  localparam int B_GIE = 7, B_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int B_RC_IRQ = 5, B_TX_IRQ = 4;
  localparam int B_SERIAL_PORT_ENABLE = 7, B_RX9 = 6, B_CONTINUOUS_RX_ENABLE = 4, B_ADDRESS_DETECT_ENABLE = 3,
                 B_FRAMING_ERROR = 2, B_OVERRUN_ERROR = 1, B_RX_NINTH_BIT_VALUE = 0;
  localparam int B_TX9 = 6, B_TRANSMIT_ENABLE = 5, B_SYNC = 4, B_HIGH_SPEED_BAUD = 2,
                 B_SHIFT_REG_EMPTY = 1, B_TX_NINTH_BIT_VALUE = 0;
  localparam int B_RCIDL = 6, B_RX_POLARITY_INVERT = 5, B_TX_POLARITY_INVERT = 4, B_SIXTEEN_BIT_BAUD = 3;

  // ****************
  // timing
  // ****************
  localparam int CLK_PERIOD_NS    = 10;
  localparam int INSTR_CYCLE_NS   = 40;
  localparam int INSTR_CYCLE_CLKS = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] TCY_LAST   = 3'(INSTR_CYCLE_CLKS - 1);
  localparam logic [3:0] TICK_LAST  = 4'hf;
  localparam logic [3:0] TICK_MID   = 4'h7;
  localparam logic [3:0] FRAME_BITS_8 = 4'ha;
  localparam logic [3:0] FRAME_BITS_9 = 4'hb;
  localparam logic [3:0] RX_LAST_8  = 4'h7;
  localparam logic [3:0] RX_LAST_9  = 4'h8;
  localparam logic [1:0] PRESCALE_X64_LAST = 2'h3;
  localparam int TX_FRAME_W = 11;
  localparam int RX_SHIFT_W = 9;

endpackage

//--- serial_tx_rx.sv
// asynchronous serial transmitter and receiver with Avalon-MM registers
// assumes rx_pin is asynchronous to sys_clk and tx_pin drives a line directly
//
// Behaviour
// - shift register loads from buffer only after stop bit, only if buffer full
// - buffer to shift register transfer lasts one instruction cycle, then flag rises
// - buffer empty flag sets regardless of its enable; writes to the flag register cannot clear it
// - cleared buffer empty flag is valid by the second instruction cycle
// - read-only shift register empty bit, no interrupt from it
// - transmit polarity bit inverts the tx line
// - setting transmit enable sets the buffer empty flag
// - ninth transmit bit sent after eight data bits when enabled
// - writing the buffer with transmit enabled starts transmission
// - receiver samples at sixteen times the bit rate
// - receive polarity bit inverts rx before data recovery
// - ninth received bit captured in receive status register
// - reception runs only while continuous receive enable is set
// - receive complete flag set per character, interrupt if enabled
// - clearing continuous receive enable clears receive errors
// - received byte read from the receive data register
// - address detect needs nine-bit mode; software clears it once addressed
// - frame is start bit, eight or nine data bits, stop bit
// - both directions shift least significant bit first
// - baud generator runs at 16 or 64 times the bit rate
`timescale 1ns/1ps
module serial_tx_rx
  import serial_port_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        rx_pin,
  output logic             tx_pin,
  output logic             irq_request
);

  // ****************
  // state
  // ****************
  typedef enum logic [1:0] {TX_IDLE, TX_LOAD, TX_SHIFT} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

  typedef struct packed {
    logic                    waitreq;
    logic [31:0]             rdata;
    logic                    irq;
    logic                    global_irq_enable;
    logic                    peripheral_irq_enable;
    logic                    rx_irq_enable;
    logic                    tx_irq_enable;
    logic                    rx_irq_priority;
    logic                    tx_irq_priority;
    logic                    serial_port_enable;
    logic                    rx_ninth_bit_enable;
    logic                    continuous_rx_enable;
    logic                    address_detect_enable;
    logic                    framing_error;
    logic                    overrun_error;
    logic                    rx_ninth_bit_value;
    logic                    tx_ninth_bit_enable;
    logic                    transmit_enable;
    logic                    sync_mode;
    logic                    high_speed_baud;
    logic                    tx_ninth_bit_value;
    logic                    rx_polarity_invert;
    logic                    tx_polarity_invert;
    logic                    sixteen_bit_baud;
    logic [7:0]              baud_divisor_high;
    logic [7:0]              baud_divisor_low;
    logic [7:0]              tx_buffer;
    logic                    buf_full;
    logic                    tx_buffer_empty_flag;
    logic [7:0]              rx_buffer;
    logic                    rx_complete_flag;
    tx_state_t               txs;
    logic [TX_FRAME_W-1:0]   tx_shift_reg;
    logic [3:0]              tx_bits;
    logic [3:0]              tx_tick;
    logic [2:0]              tcy_cnt;
    logic                    tx_line;
    logic                    tx_out;
    logic [2:0]              rx_sync;
    logic                    rx_level;
    rx_state_t               rxs;
    logic [3:0]              rx_tick;
    logic [3:0]              rx_bits;
    logic [RX_SHIFT_W-1:0]   rx_shift;
  } port_state_t;

  port_state_t s_q;
  port_state_t s_d;
  logic        sample_tick;
  logic        async_on;
  logic        bus_req;
  logic        taken;
  logic [7:0]  wd;
  logic [7:0]  rv;
  logic        rx_in;
  logic        ninth;
  logic [7:0]  rx_byte;

  function automatic logic reg_hit(input logic [5:0] a, input logic [5:0] off);
    reg_hit = (a == off);
  endfunction

  // ****************
  // baud generator
  // ****************
  serial_baud_gen u_baud (
    .sys_clk           (sys_clk),
    .rst_b             (rst_b),
    .enable            (async_on),
    .high_speed_baud   (s_q.high_speed_baud),
    .sixteen_bit_baud  (s_q.sixteen_bit_baud),
    .baud_divisor_high (s_q.baud_divisor_high),
    .baud_divisor_low  (s_q.baud_divisor_low),
    .sample_tick       (sample_tick)
  );

  // port does async work only when enabled and not in synchronous mode
  assign async_on = s_q.serial_port_enable && !s_q.sync_mode;
  assign bus_req  = avs_read || avs_write;
  assign taken    = bus_req && !s_q.waitreq;
  assign wd       = avs_writedata[7:0];

  // ****************
  // next state
  // ****************
  always_comb begin
    s_d = s_q;
    rv = 8'h00;
    rx_in = 1'b1;
    ninth = 1'b0;
    rx_byte = 8'h00;

    // bus slave: answer one cycle after the request is seen
    s_d.waitreq = !(bus_req && s_q.waitreq);
    if (bus_req && s_q.waitreq) begin
      unique case (avs_address)
        OFF_INTERRUPT_CONTROL: begin
          rv[B_GIE] = s_q.global_irq_enable;
          rv[B_PERIPHERAL_IRQ_ENABLE] = s_q.peripheral_irq_enable;
        end
        OFF_PERIPHERAL_FLAGS_ONE: begin
          rv[B_RC_IRQ] = s_q.rx_complete_flag;
          rv[B_TX_IRQ] = s_q.tx_buffer_empty_flag;
        end
        OFF_PERIPHERAL_ENABLES_ONE: begin
          rv[B_RC_IRQ] = s_q.rx_irq_enable;
          rv[B_TX_IRQ] = s_q.tx_irq_enable;
        end
        OFF_PERIPHERAL_PRIORITY_ONE: begin
          rv[B_RC_IRQ] = s_q.rx_irq_priority;
          rv[B_TX_IRQ] = s_q.tx_irq_priority;
        end
        OFF_RECEIVE_STATUS_CONTROL: begin
          rv[B_SERIAL_PORT_ENABLE] = s_q.serial_port_enable;
          rv[B_RX9] = s_q.rx_ninth_bit_enable;
          rv[B_CONTINUOUS_RX_ENABLE] = s_q.continuous_rx_enable;
          rv[B_ADDRESS_DETECT_ENABLE] = s_q.address_detect_enable;
          rv[B_FRAMING_ERROR] = s_q.framing_error;
          rv[B_OVERRUN_ERROR] = s_q.overrun_error;
          rv[B_RX_NINTH_BIT_VALUE] = s_q.rx_ninth_bit_value;
        end
        OFF_TRANSMIT_BUFFER: rv = s_q.tx_buffer;
        OFF_TRANSMIT_STATUS_CONTROL: begin
          rv[B_TX9] = s_q.tx_ninth_bit_enable;
          rv[B_TRANSMIT_ENABLE] = s_q.transmit_enable;
          rv[B_SYNC] = s_q.sync_mode;
          rv[B_HIGH_SPEED_BAUD] = s_q.high_speed_baud;
          rv[B_SHIFT_REG_EMPTY] = (s_q.txs != TX_SHIFT);
          rv[B_TX_NINTH_BIT_VALUE] = s_q.tx_ninth_bit_value;
        end
        OFF_BAUD_CONTROL: begin
          rv[B_RCIDL] = (s_q.rxs == RX_IDLE);
          rv[B_RX_POLARITY_INVERT] = s_q.rx_polarity_invert;
          rv[B_TX_POLARITY_INVERT] = s_q.tx_polarity_invert;
          rv[B_SIXTEEN_BIT_BAUD] = s_q.sixteen_bit_baud;
        end
        OFF_BAUD_DIVISOR_HIGH: rv = s_q.baud_divisor_high;
        OFF_RECEIVE_BUFFER: rv = s_q.rx_buffer;
        OFF_BAUD_DIVISOR_LOW: rv = s_q.baud_divisor_low;
        default: rv = 8'h00;
      endcase
      s_d.rdata = {24'h000000, rv};
    end

    // register writes; flag register bits are read-only
    if (taken && avs_write) begin
      if (reg_hit(avs_address, OFF_INTERRUPT_CONTROL)) begin
        s_d.global_irq_enable = wd[B_GIE];
        s_d.peripheral_irq_enable = wd[B_PERIPHERAL_IRQ_ENABLE];
      end
      if (reg_hit(avs_address, OFF_PERIPHERAL_ENABLES_ONE)) begin
        s_d.rx_irq_enable = wd[B_RC_IRQ];
        s_d.tx_irq_enable = wd[B_TX_IRQ];
      end
      if (reg_hit(avs_address, OFF_PERIPHERAL_PRIORITY_ONE)) begin
        s_d.rx_irq_priority = wd[B_RC_IRQ];
        s_d.tx_irq_priority = wd[B_TX_IRQ];
      end
      if (reg_hit(avs_address, OFF_RECEIVE_STATUS_CONTROL)) begin
        s_d.serial_port_enable = wd[B_SERIAL_PORT_ENABLE];
        s_d.rx_ninth_bit_enable = wd[B_RX9];
        s_d.continuous_rx_enable = wd[B_CONTINUOUS_RX_ENABLE];
        s_d.address_detect_enable = wd[B_ADDRESS_DETECT_ENABLE];
        if (!wd[B_CONTINUOUS_RX_ENABLE]) begin
          s_d.framing_error = 1'b0;
          s_d.overrun_error = 1'b0;
        end
      end
      if (reg_hit(avs_address, OFF_TRANSMIT_BUFFER)) begin
        s_d.tx_buffer = wd;
        s_d.buf_full = 1'b1;
      end
      if (reg_hit(avs_address, OFF_TRANSMIT_STATUS_CONTROL)) begin
        s_d.tx_ninth_bit_enable = wd[B_TX9];
        s_d.transmit_enable = wd[B_TRANSMIT_ENABLE];
        s_d.sync_mode = wd[B_SYNC];
        s_d.high_speed_baud = wd[B_HIGH_SPEED_BAUD];
        s_d.tx_ninth_bit_value = wd[B_TX_NINTH_BIT_VALUE];
      end
      if (reg_hit(avs_address, OFF_BAUD_CONTROL)) begin
        s_d.rx_polarity_invert = wd[B_RX_POLARITY_INVERT];
        s_d.tx_polarity_invert = wd[B_TX_POLARITY_INVERT];
        s_d.sixteen_bit_baud = wd[B_SIXTEEN_BIT_BAUD];
      end
      if (reg_hit(avs_address, OFF_BAUD_DIVISOR_HIGH)) begin
        s_d.baud_divisor_high = wd;
      end
      if (reg_hit(avs_address, OFF_BAUD_DIVISOR_LOW)) begin
        s_d.baud_divisor_low = wd;
      end
    end

    // reading the receive buffer frees it
    if (taken && avs_read && reg_hit(avs_address, OFF_RECEIVE_BUFFER)) begin
      s_d.rx_complete_flag = 1'b0;
    end

    // ****************
    // transmitter
    // ****************
    if (!(async_on && s_q.transmit_enable)) begin
      s_d.txs = TX_IDLE;
      s_d.tx_line = 1'b1;
    end else begin
      unique case (s_q.txs)
        TX_IDLE: begin
          if (s_q.buf_full) begin
            s_d.txs = TX_LOAD;
            s_d.tcy_cnt = 3'h0;
          end
        end
        TX_LOAD: begin
          s_d.tcy_cnt = s_q.tcy_cnt + 3'h1;
          if (s_q.tcy_cnt == TCY_LAST) begin
            // stop, ninth or extra stop, data lsb first, start
            s_d.tx_shift_reg = {1'b1,
                                s_q.tx_ninth_bit_enable ? s_q.tx_ninth_bit_value : 1'b1,
                                s_q.tx_buffer, 1'b0};
            s_d.tx_bits = s_q.tx_ninth_bit_enable ? FRAME_BITS_9 : FRAME_BITS_8;
            // a write landing with the load refills the buffer: set wins
            s_d.buf_full = taken && avs_write && reg_hit(avs_address, OFF_TRANSMIT_BUFFER);
            s_d.tx_tick = 4'h0;
            s_d.tx_line = 1'b0;
            s_d.txs = TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (sample_tick) begin
            s_d.tx_tick = s_q.tx_tick + 4'h1;
            if (s_q.tx_tick == TICK_LAST) begin
              s_d.tx_shift_reg = {1'b1, s_q.tx_shift_reg[TX_FRAME_W-1:1]};
              s_d.tx_line = s_d.tx_shift_reg[0];
              s_d.tx_bits = s_q.tx_bits - 4'h1;
              if (s_q.tx_bits == 4'h1) begin
                s_d.tx_line = 1'b1;
                s_d.txs = s_q.buf_full ? TX_LOAD : TX_IDLE;
                s_d.tcy_cnt = 3'h0;
              end
            end
          end
        end
        default: s_d.txs = TX_IDLE;
      endcase
    end
    s_d.tx_out = s_d.tx_line ^ s_q.tx_polarity_invert;

    // flag follows the buffer one clock late, well inside two cycles
    s_d.tx_buffer_empty_flag = s_q.transmit_enable && !s_q.buf_full;

    // ****************
    // receiver
    // ****************
    s_d.rx_sync = {s_q.rx_sync[1:0], rx_pin};
    if (s_q.rx_sync[1] == s_q.rx_sync[2]) begin
      s_d.rx_level = s_q.rx_sync[2];
    end
    rx_in = s_q.rx_level ^ s_q.rx_polarity_invert;

    if (!(async_on && s_q.continuous_rx_enable)) begin
      s_d.rxs = RX_IDLE;
    end else if (sample_tick) begin
      s_d.rx_tick = s_q.rx_tick + 4'h1;
      unique case (s_q.rxs)
        RX_IDLE: begin
          s_d.rx_tick = 4'h0;
          if (!rx_in) begin
            s_d.rxs = RX_START;
          end
        end
        RX_START: begin
          if (s_q.rx_tick == TICK_MID) begin
            s_d.rxs = rx_in ? RX_IDLE : RX_DATA;
            s_d.rx_tick = 4'h0;
            s_d.rx_bits = 4'h0;
          end
        end
        RX_DATA: begin
          if (s_q.rx_tick == TICK_LAST) begin
            s_d.rx_shift = {rx_in, s_q.rx_shift[RX_SHIFT_W-1:1]};
            s_d.rx_bits = s_q.rx_bits + 4'h1;
            if (s_q.rx_bits == (s_q.rx_ninth_bit_enable ? RX_LAST_9 : RX_LAST_8)) begin
              s_d.rxs = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (s_q.rx_tick == TICK_LAST) begin
            s_d.rxs = RX_IDLE;
            ninth = s_q.rx_ninth_bit_enable && s_q.rx_shift[RX_SHIFT_W-1];
            rx_byte = s_q.rx_ninth_bit_enable ? s_q.rx_shift[7:0]
                                              : s_q.rx_shift[RX_SHIFT_W-1:1];
            // address detect drops data characters
            if (!(s_q.address_detect_enable && s_q.rx_ninth_bit_enable
                  && !ninth)) begin
              if (s_d.rx_complete_flag) begin
                s_d.overrun_error = 1'b1;
              end else begin
                s_d.rx_buffer = rx_byte;
                s_d.rx_ninth_bit_value = ninth;
                s_d.framing_error = !rx_in;
                s_d.rx_complete_flag = 1'b1;
              end
            end
          end
        end
        default: s_d.rxs = RX_IDLE;
      endcase
    end

    s_d.irq = s_q.global_irq_enable && s_q.peripheral_irq_enable
              && ((s_q.rx_complete_flag && s_q.rx_irq_enable)
                  || (s_q.tx_buffer_empty_flag && s_q.tx_irq_enable));
  end

  // ****************
  // registers
  // ****************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.waitreq <= 1'b1;
      s_q.tx_line <= 1'b1;
      s_q.tx_out <= 1'b1;
      s_q.rx_sync <= 3'h7;
      s_q.rx_level <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata    = s_q.rdata;
  assign avs_waitrequest = s_q.waitreq;
  assign tx_pin          = s_q.tx_out;
  assign irq_request     = s_q.irq;

endmodule

//--- serial_tx_rx_monitor.sv
// port checks of the serial port: register bus answers and tx line timing
// assumes bind onto serial_tx_rx and a bit time of at least nine clocks
`timescale 1ns/1ps
module serial_tx_rx_monitor
  import serial_port_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        rx_pin,
  input wire logic        tx_pin,
  input wire logic        irq_request
);
  // ****************
  // shadow of the last taken transmit buffer write
  // ****************
  logic       req;
  logic [7:0] last_tx_q;
  logic [7:0] last_tx_d;
  assign req = avs_read | avs_write;
  always_comb begin
    last_tx_d = last_tx_q;
    if (avs_write && !avs_waitrequest && avs_address == OFF_TRANSMIT_BUFFER) begin
      last_tx_d = avs_writedata[7:0];
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      last_tx_q <= 8'h00;
    end else begin
      last_tx_q <= last_tx_d;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wait_pulse_a: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  answer_next_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in the next cycle");
  answer_cause_a: assert property (!avs_waitrequest |-> req && $past(req))
    else $error("answer without a pending request");
  upper_zero_a: assert property (avs_readdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address == 6'h3c
    |-> avs_readdata == 32'h00000000) else $error("unmapped read not zero");
  readdata_hold_a: assert property (!req && avs_waitrequest |=> $stable(avs_readdata))
    else $error("read data moved without a request");
  txbuf_readback_a: assert property (avs_read && !avs_waitrequest
    && avs_address == OFF_TRANSMIT_BUFFER |-> avs_readdata[7:0] == last_tx_q)
    else $error("transmit buffer read back differs");
  reset_idle_a: assert property ($rose(rst_b) |-> tx_pin && !irq_request && avs_waitrequest)
    else $error("outputs not idle after reset");
  tx_bit_hold_a: assert property ($changed(tx_pin) |=> $stable(tx_pin)[*8])
    else $error("tx level shorter than a bit");
endmodule
bind serial_tx_rx serial_tx_rx_monitor serial_tx_rx_monitor_i (
  .sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .rx_pin(rx_pin), .tx_pin(tx_pin),
  .irq_request(irq_request));
